// File: rtl/status_ind_pkg.sv
// Constants, register map and types shared by the status indicator controller.
// Behaviour
// - Target indicator shows green while a target is inside the operating range.
// - Target indicator shows red while no target is inside the operating range.
// - Target near minimum range makes the indicator flash green quickly.
// - Target indicator stays lit red or green in normal operation.
// - Unlocked: target colour still shown but gated slowly on and off.
// - Alternate adjust state replaces the slow blink with a double blink.
// - All measurement filters are off while unlocked.
// - Held button blinks red slowly unless adjust disabled and not synced.
// - Feedback flashes are counted; release starts the matching adjust function.
// - Slave without sync input stops measuring and alternates red and green.
// - Each status indicator selects analog, switch, receive, transmit or off.
// - Reset gives square indicator analog, rectangular indicator transmit.
// - Switch source: square follows switch one, rectangular follows switch two.
// - Switch indicator follows switch state and blinks during safe shutdown.
// - Switch counts as on when conducting, same for sinking or sourcing.
// - Analog indicator steady on while distance lies strictly between endpoints.
// - Analog indicator off at or beyond the low value endpoint.
// - Analog indicator flashes fast at or beyond the high value endpoint.
// - Receive flashes on any incoming data; transmit flashes on command replies.
// - In streaming mode the transmit indicator flashes on every transmission.
// - Fault forces the affected switch off; it resumes when the fault clears.
// - No target: hold analog, switches off after one second, both configurable.
package status_ind_pkg;

  localparam int          CLK_MHZ            = 250;
  localparam int          ADDR_W             = 8;
  localparam int          DATA_W             = 32;
  localparam int          DIV_W              = 24;
  localparam int          TDIST_W            = 16;
  localparam int          ADJ_CNT_W          = 8;
  localparam int          CTRL_W             = 9;
  localparam int          NUM_SW             = 2;
  localparam int          PIN_W              = 6;

  localparam logic [ADDR_W-1:0] CTRL_OFFSET     = 8'h00;
  localparam logic [ADDR_W-1:0] SLOW_DIV_OFFSET = 8'h04;
  localparam logic [ADDR_W-1:0] FAST_DIV_OFFSET = 8'h08;
  localparam logic [ADDR_W-1:0] ACT_DIV_OFFSET  = 8'h0C;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET   = 8'h10;

  // Control register fields.
  localparam int          SQ_SRC_LSB         = 0;
  localparam int          RECT_SRC_LSB       = 3;
  localparam int          SRC_W              = 3;
  localparam int          NT_SW_OFF_BIT      = 6;
  localparam int          NT_HOLD_BIT        = 7;
  localparam int          ADJ_EN_BIT         = 8;
  localparam logic [CTRL_W-1:0] CTRL_RESET   = 9'h1E1;

  // Status register fields.
  localparam int          ST_TARGET_BIT      = 0;
  localparam int          ST_NEAR_BIT        = 1;
  localparam int          ST_UNLOCK_BIT      = 2;
  localparam int          ST_ALT_BIT         = 3;
  localparam int          ST_NOSYNC_BIT      = 4;
  localparam int          ST_FAULT_LSB       = 5;
  localparam int          ST_SW_ON_LSB       = 7;
  localparam int          ST_NT_TIMEOUT_BIT  = 9;
  localparam int          ST_ADJ_CODE_LSB    = 10;

  // Pin bundle positions after synchronisation.
  localparam int          PIN_BUTTON         = 0;
  localparam int          PIN_SYNC           = 1;
  localparam int          PIN_OVLD_LSB       = 2;
  localparam int          PIN_OVTEMP_LSB     = 4;

  // Timing: one slow step is an eighth of a slow blink period.
  localparam int          SLOW_STEP_US       = 31250;
  localparam int          FAST_HALF_US       = 62500;
  localparam int          ACT_FLASH_US       = 50000;
  localparam int          NOTARGET_TIME_MS   = 1000;
  localparam logic [DIV_W-1:0] SLOW_DIV_RESET = DIV_W'(SLOW_STEP_US * CLK_MHZ);
  localparam logic [DIV_W-1:0] FAST_DIV_RESET = DIV_W'(FAST_HALF_US * CLK_MHZ);
  localparam logic [DIV_W-1:0] ACT_DIV_RESET  = DIV_W'(ACT_FLASH_US * CLK_MHZ);
  localparam int          NOTARGET_CYCLES    = NOTARGET_TIME_MS * 1000 * CLK_MHZ;

  typedef enum logic [SRC_W-1:0] {
    src_off,
    src_analog,
    src_switch,
    src_rx,
    src_tx
  } src_t;

  typedef enum logic [1:0] {
    ana_low,
    ana_mid,
    ana_high
  } ana_t;

endpackage

// File: rtl/blink_if.sv
// Divider settings and blink phases passed between the controller and its timebase.
`timescale 1ns/100ps
interface blink_if;
  import status_ind_pkg::*;
  logic [DIV_W-1:0] slow_div;
  logic [DIV_W-1:0] fast_div;
  logic             slow;
  logic             fast;
  logic             dbl;
  logic             slow_rise;
  modport gen   (input slow_div, input fast_div, output slow, output fast, output dbl,
                 output slow_rise);
  modport sink  (output slow_div, output fast_div, input slow, input fast, input dbl,
                 input slow_rise);
endinterface

// File: rtl/blink_timebase.sv
// Blink phase generator for slow, fast and double-blink patterns.
`timescale 1ns/100ps
module blink_timebase (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic ce,
  blink_if.gen      tb
);
  import status_ind_pkg::*;

  logic [DIV_W-1:0] step_cnt_reg;
  logic [DIV_W-1:0] fast_cnt_reg;
  logic [2:0]       step_reg;
  logic             fast_reg;
  logic             rise_reg;

  // A divider of zero behaves as one, so a bad write cannot stall the patterns.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      step_cnt_reg <= '0;
      step_reg     <= '0;
      rise_reg     <= 1'b0;
    end else if (ce) begin
      rise_reg <= 1'b0;
      if (step_cnt_reg + DIV_W'(1) >= tb.slow_div) begin
        step_cnt_reg <= '0;
        step_reg     <= step_reg + 3'h1;
        rise_reg     <= (step_reg == 3'h3);
      end else begin
        step_cnt_reg <= step_cnt_reg + DIV_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      fast_cnt_reg <= '0;
      fast_reg     <= 1'b0;
    end else if (ce) begin
      if (fast_cnt_reg + DIV_W'(1) >= tb.fast_div) begin
        fast_cnt_reg <= '0;
        fast_reg     <= !fast_reg;
      end else begin
        fast_cnt_reg <= fast_cnt_reg + DIV_W'(1);
      end
    end
  end

  assign tb.slow      = step_reg[2];
  // Two short blinks in the lit half, then a dark half.
  assign tb.dbl       = step_reg[2] & step_reg[0];
  assign tb.fast      = fast_reg;
  assign tb.slow_rise = rise_reg;
endmodule

// File: rtl/status_indicator_controller.sv
// Target and output status indicator controller with switch gating and adjust feedback.
`timescale 1ns/100ps
module status_indicator_controller #(
  parameter int unsigned NOTARGET_CNT = status_ind_pkg::NOTARGET_CYCLES
) (
  input  wire logic                                  clk,
  input  wire logic                                  reset_n,
  input  wire logic                                  ce,
  input  wire logic [status_ind_pkg::ADDR_W-1:0]     addr,
  input  wire logic [status_ind_pkg::DATA_W-1:0]     wdata,
  input  wire logic                                  wr_en,
  input  wire logic                                  rd_en,
  output logic      [status_ind_pkg::DATA_W-1:0]     rdata,
  input  wire logic                                  target_detected,
  input  wire logic                                  near_min,
  input  wire logic                                  unlocked,
  input  wire logic                                  alternate_adjust_state,
  input  wire logic                                  sync_master,
  input  wire logic                                  sync_slave,
  input  wire logic [status_ind_pkg::TDIST_W-1:0]    target_distance,
  input  wire logic [status_ind_pkg::TDIST_W-1:0]    low_endpoint,
  input  wire logic [status_ind_pkg::TDIST_W-1:0]    high_endpoint,
  input  wire logic [status_ind_pkg::NUM_SW-1:0]     sw_request,
  input  wire logic                                  rx_activity,
  input  wire logic                                  tx_reply,
  input  wire logic                                  tx_char,
  input  wire logic                                  streaming_mode,
  input  wire logic                                  adjust_button,
  input  wire logic                                  sync_in,
  input  wire logic [status_ind_pkg::NUM_SW-1:0]     sw_overload,
  input  wire logic [status_ind_pkg::NUM_SW-1:0]     sw_overtemp,
  output logic                                       led_target_red,
  output logic                                       led_target_green,
  output logic                                       led_square,
  output logic                                       led_rect,
  output logic      [status_ind_pkg::NUM_SW-1:0]     sw_drive,
  output logic                                       analog_hold,
  output logic                                       filters_off,
  output logic                                       measure_stop,
  output logic                                       adjust_strobe,
  output logic      [status_ind_pkg::ADJ_CNT_W-1:0]  adjust_code
);
  import status_ind_pkg::*;

  localparam int NT_W = $clog2(NOTARGET_CNT + 1);

  blink_if tb ();

  logic [CTRL_W-1:0]    ctrl_reg;
  logic [DIV_W-1:0]     slow_div_reg;
  logic [DIV_W-1:0]     fast_div_reg;
  logic [DIV_W-1:0]     act_div_reg;
  logic [DATA_W-1:0]    rdata_reg;
  logic [PIN_W-1:0]     pin_meta_reg;
  logic [PIN_W-1:0]     pin_sync_reg;
  logic                 button_prev_reg;
  logic [ADJ_CNT_W-1:0] flash_cnt_reg;
  logic                 fb_seen_reg;
  logic                 adjust_strobe_reg;
  logic [ADJ_CNT_W-1:0] adjust_code_reg;
  logic [NT_W-1:0]      nt_cnt_reg;
  logic                 nt_timeout_reg;
  logic [NUM_SW-1:0]    sw_drive_reg;
  logic [DIV_W-1:0]     rx_cnt_reg;
  logic [DIV_W-1:0]     tx_cnt_reg;
  logic                 red_reg;
  logic                 green_reg;
  logic                 red_next;
  logic                 green_next;
  logic                 square_reg;
  logic                 rect_reg;
  logic                 analog_hold_reg;
  logic                 filters_off_reg;
  logic                 measure_stop_reg;

  logic                 button_held;
  logic                 sync_ok;
  logic [NUM_SW-1:0]    sw_fault;
  logic                 nosync;
  logic                 fb_active;
  logic                 gate;
  logic                 rx_on;
  logic                 tx_on;
  logic                 tx_event;
  ana_t                 zone;
  logic [NUM_SW-1:0]    sw_drive_next;

  // Works for either analog slope: the low endpoint may lie nearer or farther.
  function automatic ana_t analog_zone(input logic [TDIST_W-1:0] d,
                                       input logic [TDIST_W-1:0] lo,
                                       input logic [TDIST_W-1:0] hi);
    logic inc;
    inc = (lo <= hi);
    if (inc ? (d <= lo) : (d >= lo)) begin
      return ana_low;
    end else if (inc ? (d >= hi) : (d <= hi)) begin
      return ana_high;
    end
    return ana_mid;
  endfunction

  function automatic logic indicator_level(input logic [SRC_W-1:0] sel,
                                           input ana_t             az,
                                           input logic             sw_on,
                                           input logic             sw_flt,
                                           input logic             rx_lit,
                                           input logic             tx_lit,
                                           input logic             slow,
                                           input logic             fast);
    logic lit;
    lit = 1'b0;
    case (sel)
      src_analog: begin
        lit = (az == ana_mid) | ((az == ana_high) & fast);
      end
      src_switch: begin
        lit = sw_flt ? slow : sw_on;
      end
      src_rx: begin
        lit = rx_lit;
      end
      src_tx: begin
        lit = tx_lit;
      end
      default: begin
        lit = 1'b0;
      end
    endcase
    return lit;
  endfunction

  blink_timebase u_timebase (
    .clk     (clk),
    .reset_n (reset_n),
    .ce      (ce),
    .tb      (tb.gen)
  );

  assign tb.slow_div = slow_div_reg;
  assign tb.fast_div = fast_div_reg;

  // Register writes.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ctrl_reg     <= CTRL_RESET;
      slow_div_reg <= SLOW_DIV_RESET;
      fast_div_reg <= FAST_DIV_RESET;
      act_div_reg  <= ACT_DIV_RESET;
    end else if (ce && wr_en) begin
      unique case (addr)
        CTRL_OFFSET:     ctrl_reg     <= wdata[CTRL_W-1:0];
        SLOW_DIV_OFFSET: slow_div_reg <= wdata[DIV_W-1:0];
        FAST_DIV_OFFSET: fast_div_reg <= wdata[DIV_W-1:0];
        ACT_DIV_OFFSET:  act_div_reg  <= wdata[DIV_W-1:0];
        default: begin
        end
      endcase
    end
  end

  // Read data stand for exactly the cycle after the strobe; unmapped reads return zero.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata_reg <= '0;
    end else if (ce) begin
      rdata_reg <= '0;
      if (rd_en) begin
        unique case (addr)
          CTRL_OFFSET:     rdata_reg <= DATA_W'(ctrl_reg);
          SLOW_DIV_OFFSET: rdata_reg <= DATA_W'(slow_div_reg);
          FAST_DIV_OFFSET: rdata_reg <= DATA_W'(fast_div_reg);
          ACT_DIV_OFFSET:  rdata_reg <= DATA_W'(act_div_reg);
          STATUS_OFFSET: begin
            rdata_reg[ST_TARGET_BIT]                          <= target_detected;
            rdata_reg[ST_NEAR_BIT]                            <= near_min;
            rdata_reg[ST_UNLOCK_BIT]                          <= unlocked;
            rdata_reg[ST_ALT_BIT]                             <= alternate_adjust_state;
            rdata_reg[ST_NOSYNC_BIT]                          <= nosync;
            rdata_reg[ST_FAULT_LSB +: NUM_SW]                 <= sw_fault;
            rdata_reg[ST_SW_ON_LSB +: NUM_SW]                 <= sw_drive_reg;
            rdata_reg[ST_NT_TIMEOUT_BIT]                      <= nt_timeout_reg;
            rdata_reg[ST_ADJ_CODE_LSB +: ADJ_CNT_W]           <= adjust_code_reg;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // Pins from outside the clock domain pass two flip-flops before use.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pin_meta_reg <= '0;
      pin_sync_reg <= '0;
    end else if (ce) begin
      pin_meta_reg <= {sw_overtemp, sw_overload, sync_in, adjust_button};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  assign button_held = pin_sync_reg[PIN_BUTTON];
  assign sync_ok     = pin_sync_reg[PIN_SYNC];
  assign sw_fault    = pin_sync_reg[PIN_OVLD_LSB +: NUM_SW] |
                       pin_sync_reg[PIN_OVTEMP_LSB +: NUM_SW];
  assign nosync      = sync_slave & !sync_ok;
  // Feedback is withheld only for a disabled button on a sensor outside any sync group.
  assign fb_active   = button_held &
                       (ctrl_reg[ADJ_EN_BIT] | sync_master | sync_slave);
  assign gate        = alternate_adjust_state ? tb.dbl : tb.slow;
  assign zone        = analog_zone(target_distance, low_endpoint, high_endpoint);
  assign rx_on       = (rx_cnt_reg != '0);
  assign tx_on       = (tx_cnt_reg != '0);
  assign tx_event    = tx_reply | (streaming_mode & tx_char);

  // Adjust feedback: count slow flashes while held, report the count on release.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      button_prev_reg   <= 1'b0;
      flash_cnt_reg     <= '0;
      fb_seen_reg       <= 1'b0;
      adjust_strobe_reg <= 1'b0;
      adjust_code_reg   <= '0;
    end else if (ce) begin
      button_prev_reg   <= button_held;
      adjust_strobe_reg <= 1'b0;
      if (fb_active) begin
        fb_seen_reg <= 1'b1;
        if (tb.slow_rise && flash_cnt_reg != '1) begin
          flash_cnt_reg <= flash_cnt_reg + ADJ_CNT_W'(1);
        end
      end
      if (button_prev_reg && !button_held) begin
        adjust_strobe_reg <= fb_seen_reg;
        if (fb_seen_reg) begin
          adjust_code_reg <= flash_cnt_reg;
        end
        flash_cnt_reg <= '0;
        fb_seen_reg   <= 1'b0;
      end
    end
  end

  // No-target timer; it restarts whenever a target is seen again.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      nt_cnt_reg     <= '0;
      nt_timeout_reg <= 1'b0;
    end else if (ce) begin
      if (target_detected) begin
        nt_cnt_reg     <= '0;
        nt_timeout_reg <= 1'b0;
      end else if (nt_cnt_reg + NT_W'(1) >= NT_W'(NOTARGET_CNT)) begin
        nt_timeout_reg <= 1'b1;
      end else begin
        nt_cnt_reg <= nt_cnt_reg + NT_W'(1);
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_SW; i++) begin
      sw_drive_next[i] = sw_request[i] & !sw_fault[i] &
                         !(nt_timeout_reg & ctrl_reg[NT_SW_OFF_BIT]);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sw_drive_reg     <= '0;
      analog_hold_reg  <= 1'b0;
      filters_off_reg  <= 1'b0;
      measure_stop_reg <= 1'b0;
    end else if (ce) begin
      sw_drive_reg     <= sw_drive_next;
      analog_hold_reg  <= !target_detected & ctrl_reg[NT_HOLD_BIT];
      filters_off_reg  <= unlocked;
      measure_stop_reg <= nosync;
    end
  end

  // Activity flashes: a short event is stretched so the eye can see it.
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rx_cnt_reg <= '0;
      tx_cnt_reg <= '0;
    end else if (ce) begin
      if (rx_activity) begin
        rx_cnt_reg <= act_div_reg;
      end else if (rx_on) begin
        rx_cnt_reg <= rx_cnt_reg - DIV_W'(1);
      end
      if (tx_event) begin
        tx_cnt_reg <= act_div_reg;
      end else if (tx_on) begin
        tx_cnt_reg <= tx_cnt_reg - DIV_W'(1);
      end
    end
  end

  // Target colour priority: missing sync, then button feedback, then target status.
  always_comb begin
    red_next   = 1'b0;
    green_next = 1'b0;
    if (nosync) begin
      red_next   = tb.slow;
      green_next = !tb.slow;
    end else if (fb_active) begin
      red_next = alternate_adjust_state ? tb.dbl : tb.slow;
    end else begin
      if (target_detected && near_min) begin
        green_next = tb.fast;
      end else begin
        green_next = target_detected;
        red_next   = !target_detected;
      end
      if (unlocked) begin
        red_next   = red_next & gate;
        green_next = green_next & gate;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      red_reg    <= 1'b0;
      green_reg  <= 1'b0;
      square_reg <= 1'b0;
      rect_reg   <= 1'b0;
    end else if (ce) begin
      red_reg    <= red_next;
      green_reg  <= green_next;
      square_reg <= indicator_level(ctrl_reg[SQ_SRC_LSB +: SRC_W], zone,
                                    sw_drive_reg[0], sw_fault[0], rx_on, tx_on,
                                    tb.slow, tb.fast);
      rect_reg   <= indicator_level(ctrl_reg[RECT_SRC_LSB +: SRC_W], zone,
                                    sw_drive_reg[1], sw_fault[1], rx_on, tx_on,
                                    tb.slow, tb.fast);
    end
  end

  assign rdata            = rdata_reg;
  assign led_target_red   = red_reg;
  assign led_target_green = green_reg;
  assign led_square       = square_reg;
  assign led_rect         = rect_reg;
  assign sw_drive         = sw_drive_reg;
  assign analog_hold      = analog_hold_reg;
  assign filters_off      = filters_off_reg;
  assign measure_stop     = measure_stop_reg;
  assign adjust_strobe    = adjust_strobe_reg;
  assign adjust_code      = adjust_code_reg;

endmodule

// File: sim/status_props.sv
// Port-level assertion checker for the status indicator controller.
`timescale 1ns/100ps
module status_props
  import status_ind_pkg::*;
#(
  parameter int unsigned NOTARGET_CNT = 50
) (
  input  wire logic                 clk, reset_n, ce, rd_en,
  input  wire logic [DATA_W-1:0]    rdata,
  input  wire logic                 target_detected, near_min, unlocked, sync_slave,
  input  wire logic                 adjust_button, sync_in, adjust_strobe,
  input  wire logic [NUM_SW-1:0]    sw_request, sw_overload, sw_overtemp, sw_drive,
  input  wire logic                 led_target_red, led_target_green, filters_off, measure_stop
);
  logic [31:0] nt_reg;

  // Counts consecutive edges without a target; saturates so it never wraps back to zero.
  always_ff @(posedge clk) begin
    if (!reset_n || target_detected) nt_reg <= '0;
    else if (ce && nt_reg != 32'hFFFFFFFF) nt_reg <= nt_reg + 32'h1;
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Three quiet samples cover the two-flop button synchroniser.
  sequence calm_s;
    (ce && !adjust_button && !unlocked && !sync_slave)[*3];
  endsequence
  sequence flt0_s;
    (ce && sw_overload[0])[*4];
  endsequence

  a_rdata_idle: assert property (ce && !rd_en |=> rdata == '0) else $error("read data not idle");
  a_green_target: assert property (calm_s ##0 (target_detected && !near_min) |=>
    led_target_green && !led_target_red) else $error("target lamp not green");
  a_red_notarget: assert property (calm_s ##0 !target_detected |=>
    led_target_red && !led_target_green) else $error("target lamp not red");
  a_near_fast: assert property (calm_s ##0 (target_detected && near_min) |=>
    !led_target_red) else $error("near minimum shows red");
  a_filters_unlock: assert property (ce |=> filters_off == $past(unlocked))
    else $error("filters do not follow unlock");
  a_nosync_alt: assert property ((ce && sync_slave && !sync_in)[*4] |->
    measure_stop && led_target_red != led_target_green) else $error("missing sync not shown");
  a_fault_off: assert property (flt0_s |-> !sw_drive[0]) else $error("overload switch on");
  a_temp_off: assert property ((ce && sw_overtemp[1])[*4] |-> !sw_drive[1])
    else $error("overtemp switch on");
  a_switch_on: assert property ((ce && target_detected && sw_request[1] && !sw_overload[1]
    && !sw_overtemp[1])[*4] |-> sw_drive[1]) else $error("switch not conducting");
  a_strobe_pulse: assert property (adjust_strobe |=> !adjust_strobe)
    else $error("adjust strobe too long");
  a_notarget_off: assert property (nt_reg > NOTARGET_CNT + 2 |-> sw_drive == '0)
    else $error("switches on after no-target time");
endmodule
bind status_indicator_controller status_props #(.NOTARGET_CNT(NOTARGET_CNT)) status_props_i (.*);

// File: sim/led_viewer.sv
// Operator view of the two output status lamps, counting each time one lights up.
`timescale 1ns/100ps
module led_viewer (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        led_square,
  input  wire logic        led_rect,
  output logic      [15:0] sq_rises,
  output logic      [15:0] rect_rises
);
  logic sq_reg, rect_reg;

  always_ff @(posedge clk) begin
    sq_reg <= led_square;
    rect_reg <= led_rect;
    sq_rises <= !reset_n ? '0 : sq_rises + 16'(led_square && !sq_reg);
    rect_rises <= !reset_n ? '0 : rect_rises + 16'(led_rect && !rect_reg);
  end
endmodule

// File: sim/status_indicator_controller_test.sv
// Self-checking bench for the status indicator controller.
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
  $display("Error %0t: got %h expected %h", $time, g, e); end end
module status_indicator_controller_test;
  import status_ind_pkg::*;
  localparam int NT = 50;
  logic clk = 0, reset_n = 0, ce = 1, wr_en = 0, rd_en = 0, seen;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0, rdata, r;
  logic target_detected = 0, near_min = 0, unlocked = 0, alternate_adjust_state = 0;
  logic sync_master = 0, sync_slave = 0, rx_activity = 0, tx_reply = 0, tx_char = 0;
  logic streaming_mode = 0, adjust_button = 0, sync_in = 1;
  logic [TDIST_W-1:0] target_distance = '0, low_endpoint = 16'h0064, high_endpoint = 16'h00C8, d;
  logic [NUM_SW-1:0] sw_request = '0, sw_overload = '0, sw_overtemp = '0, sw_drive;
  logic led_target_red, led_target_green, led_square, led_rect;
  logic analog_hold, filters_off, measure_stop, adjust_strobe;
  logic [ADJ_CNT_W-1:0] adjust_code;
  logic [15:0] sq_rises, rect_rises, n0;
  logic [31:0] seed = 32'h7A45;
  int bad_count = 0, comparisons = 0, i, j;

  status_indicator_controller #(.NOTARGET_CNT(NT)) status_indicator_controller_i (.*);
  led_viewer led_viewer_i (.*);

  initial begin
    forever #2 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic ana_on(input logic [TDIST_W-1:0] v);
    return v > low_endpoint && v < high_endpoint;
  endfunction

  // Ends at a falling edge so that registered outputs are settled when looked at.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clk);
    {wr_en, addr, wdata} <= {1'b1, a, v};
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clk);
    {rd_en, addr} <= {1'b1, a};
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    `CHK(rdata, e)
  endtask
  task automatic pulse(input logic [2:0] p);
    @(posedge clk);
    {tx_reply, tx_char, rx_activity} <= p;
    @(posedge clk);
    {tx_reply, tx_char, rx_activity} <= 3'h0;
    cyc(2);
  endtask
  task automatic wrap_up();
    if (bad_count == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    rd(CTRL_OFFSET, 32'(CTRL_RESET));
    rd(SLOW_DIV_OFFSET, 32'(SLOW_DIV_RESET));
    wr(SLOW_DIV_OFFSET, 32'hFF000004);
    wr(FAST_DIV_OFFSET, 32'h00000004);
    wr(ACT_DIV_OFFSET, 32'h00000004);
    wr(8'h14, 32'h00000003);
    rd(8'h14, 32'h00000000);
    rd(SLOW_DIV_OFFSET, 32'h00000004);
    for (i = 0; i < 16; i++) begin
      r = xs();
      @(posedge clk);
      {near_min, target_detected} <= r[1:0];
      cyc(2);
      `CHK(led_target_red, ~r[0])
      if (r[1:0] != 2'h3) `CHK(led_target_green, r[0])
    end
    wr(CTRL_OFFSET, 32'h000001D2);
    @(posedge clk);
    {target_detected, near_min, sw_request} <= 4'b1001;
    cyc(4);
    `CHK({led_rect, led_square, sw_drive}, 4'b0101)
    n0 = sq_rises;
    @(posedge clk);
    sw_overload <= 2'b01;
    cyc(4);
    `CHK(sw_drive, 2'b00)
    cyc(72);
    `CHK(sq_rises - n0 > 16'h0001, 1'b1)
    @(posedge clk);
    {sw_overload, sw_overtemp, sw_request} <= 6'b001011;
    cyc(5);
    `CHK({led_square, sw_drive}, 3'b101)
    @(posedge clk);
    sw_overtemp <= 2'b00;
    cyc(5);
    `CHK({led_rect, sw_drive}, 3'b111)
    wr(CTRL_OFFSET, 32'h000001C1);
    for (i = 0; i < 16; i++) begin
      r = xs();
      d = (i == 0) ? 16'h0064 : 16'(r[7:0] % 8'hC8);
      @(posedge clk);
      target_distance <= d;
      cyc(3);
      `CHK(led_square, ana_on(d))
    end
    n0 = sq_rises;
    @(posedge clk);
    target_distance <= 16'h00C8;
    cyc(40);
    `CHK(sq_rises - n0 > 16'h0002, 1'b1)
    wr(CTRL_OFFSET, 32'h000001E3);
    cyc(12);
    pulse(3'b011);
    `CHK({led_rect, led_square}, 2'b01)
    cyc(10);
    `CHK(led_square, 1'b0)
    streaming_mode <= 1'b1;
    pulse(3'b010);
    `CHK(led_rect, 1'b1)
    streaming_mode <= 1'b0;
    cyc(10);
    pulse(3'b100);
    `CHK(led_rect, 1'b1)
    @(posedge clk);
    {unlocked, sync_slave, sync_in} <= 3'b110;
    cyc(6);
    `CHK({filters_off, measure_stop, led_target_red ^ led_target_green}, 3'b111)
    @(posedge clk);
    {unlocked, sync_slave, sync_in} <= 3'b001;
    cyc(6);
    `CHK({filters_off, measure_stop}, 2'b00)
    for (j = 0; j < 2; j++) begin
      wr(CTRL_OFFSET, j ? 32'h000001E3 : 32'h000000E3);
      @(posedge clk);
      adjust_button <= 1'b1;
      cyc(100);
      adjust_button <= 1'b0;
      seen = 1'b0;
      repeat (12) begin
        cyc(1);
        seen = seen | (adjust_strobe === 1'b1);
      end
      `CHK(seen, j[0])
      if (j == 1) `CHK(adjust_code inside {[8'h02:8'h04]}, 1'b1)
    end
    @(posedge clk);
    {target_detected, sw_request} <= 3'b011;
    cyc(10);
    `CHK(sw_drive, 2'b11)
    cyc(NT);
    `CHK({analog_hold, sw_drive}, 3'b100)
    wrap_up();
  end
endmodule
